// file: design/dmb_regs.svh
/*
 Constants of the banked data memory decoder: register indexes, address
 windows, bank counts, implemented-location masks and reset values.
 Assumes it is included by bare name from the package and the modules.
*/
// What this block does
// R1: Locations 10h-17h banked by low select nibble
// R2: Unbanked special locations ignore bank select
// R3: RAM windows 20h-FFh banked by high nibble
// R4: Other RAM locations common to all banks
// R5: Core registers unbanked, peripheral registers banked
// R6: Special registers held in static flip-flops
// R7: Unimplemented locations read as zero
// R8: Small variant omits RAM bank 3
// R9: Peripheral bank 8 only on large variant
// R10: Literal load of peripheral bank number
// R11: Literal load of RAM bank number
// R12: Indirect accesses use same bank bits
// R13: Storage index joins bank and low address
`ifndef DMB_REGS_SVH
`define DMB_REGS_SVH

`define DMB_IDX_BANK_SELECT  8'h0F
`define DMB_IDX_VARIANT      8'h10
`define DMB_IDX_STATUS       8'h11

`define DMB_BANK_SELECT_RST  8'h00
`define DMB_VARIANT_RST      2'h3

`define DMB_VAR_RAM3_BIT     0
`define DMB_VAR_PER8_BIT     1

`define DMB_CSFR_LO          8'h00
`define DMB_CSFR_HI          8'h0E
`define DMB_PSFR_LO          8'h10
`define DMB_PSFR_HI          8'h17
`define DMB_CSFR2_LO         8'h18
`define DMB_CSFR2_HI         8'h19
`define DMB_CGPR_LO          8'h1A
`define DMB_CGPR_HI          8'h1F
`define DMB_BGPR_LO          8'h20

`define DMB_PBANKS           9
`define DMB_RBANKS           4
`define DMB_BGPR_SPAN        224
`define DMB_CGPR_DEPTH       6
`define DMB_LAST_PBANK       4'h8
`define DMB_LAST_RBANK       4'h3

// One byte per peripheral bank, bit n set when location 10h+n exists
`define DMB_PMASK            72'h0F_7F_1F_FF_FB_FF_FF_FF_FF

`endif

// file: design/dmb_pkg.sv
/*
 Types shared by the data memory bank decoder modules.
 Assumes the constants header sits beside it.
*/
`include "dmb_regs.svh"

package dmb_pkg;

	typedef enum logic [2:0] {
		DMB_REG_NONE,
		DMB_REG_CORE_SFR,
		DMB_REG_BANK_SEL,
		DMB_REG_PERIPH,
		DMB_REG_COMMON_GPR,
		DMB_REG_BANKED_GPR
	} dmb_region_e;

	typedef logic [7:0] dmb_byte_t;

endpackage

// file: design/dmb_store.sv
/*
 Flip-flop storage array, one write port, one combinational read port.
 Assumes indexes are in range when the enables are high.
*/
`timescale 1ns/100ps

module dmb_store #(
	parameter int W     = 8,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic          clock,
	input  wire logic          resetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] widx,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] ridx,
	output logic      [W-1:0]  rdata
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
	} dmb_store_s;

	dmb_store_s st_q;
	dmb_store_s st_d;

	// Static cells: a value stays until the next write, no refresh
	always_comb begin
		st_d = st_q;
		if (we && (int'(widx) < DEPTH)) begin
			st_d.mem[widx] = wdata; // R6
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata = (int'(ridx) < DEPTH) ? st_q.mem[ridx] : '0;

endmodule

// file: design/dmb_decode.sv
/*
 Combinational address decoder: splits an 8-bit file address into
 regions and forms physical storage indexes from the bank select value.
 Assumes direct and pointer addresses arrive on the same input.
*/
`timescale 1ns/100ps
`include "dmb_regs.svh"

module dmb_decode (
	input  wire logic [7:0]          addr,
	input  wire logic [7:0]          bank_select,
	input  wire logic                ram3_en,
	input  wire logic                per8_en,
	output dmb_pkg::dmb_region_e     region,
	output logic                     impl,
	output logic [6:0]               pidx,
	output logic [2:0]               cidx,
	output logic [9:0]               gidx
);

	logic [3:0]  pbank;
	logic [3:0]  rbank;
	logic [71:0] pmask;
	logic [7:0]  off;

	assign pbank = bank_select[3:0];
	assign rbank = bank_select[7:4];
	assign pmask = `DMB_PMASK;
	assign off   = addr - `DMB_BGPR_LO;

	always_comb begin
		region = dmb_pkg::DMB_REG_NONE;
		impl   = 1'b0;
		pidx   = {pbank, addr[2:0]}; // R13
		cidx   = 3'(addr - `DMB_CGPR_LO);
		gidx   = 10'(10'(rbank[1:0]) * 10'd`DMB_BGPR_SPAN + 10'(off)); // R13
		// Same decode for direct and pointer addresses
		if (addr == `DMB_IDX_BANK_SELECT) begin // R12
			region = dmb_pkg::DMB_REG_BANK_SEL;
			impl   = 1'b1;
		end else if (addr <= `DMB_CSFR_HI) begin
			region = dmb_pkg::DMB_REG_CORE_SFR; // R2
			impl   = 1'b1; // R5
		end else if (addr >= `DMB_PSFR_LO && addr <= `DMB_PSFR_HI) begin
			region = dmb_pkg::DMB_REG_PERIPH; // R1
			if (pbank < `DMB_LAST_PBANK) begin
				impl = pmask[{pbank, addr[2:0]}]; // R5
			end else if (pbank == `DMB_LAST_PBANK) begin
				impl = per8_en && pmask[{pbank, addr[2:0]}]; // R9
			end
		end else if (addr >= `DMB_CSFR2_LO && addr <= `DMB_CSFR2_HI) begin
			region = dmb_pkg::DMB_REG_CORE_SFR; // R2
			impl   = 1'b1;
		end else if (addr >= `DMB_CGPR_LO && addr <= `DMB_CGPR_HI) begin
			region = dmb_pkg::DMB_REG_COMMON_GPR; // R4
			impl   = 1'b1;
		end else begin
			region = dmb_pkg::DMB_REG_BANKED_GPR; // R3
			if (rbank < `DMB_LAST_RBANK) begin
				impl = 1'b1;
			end else if (rbank == `DMB_LAST_RBANK) begin
				impl = ram3_en; // R8
			end
		end
	end

endmodule

// file: design/dmb_top.sv
/*
 Banked data memory decoder top: core access port, bank select register,
 literal bank load strobes, peripheral and RAM storage, and an APB slave
 for the bank select, variant and status registers.
 Assumes the core runs on the same clock and issues at most one of read
 or write per cycle; unbanked core registers other than bank select live
 in the core and are returned on core_sfr_rdata.
*/
`timescale 1ns/100ps
`include "dmb_regs.svh"

module dmb_top #(
	parameter bit HAS_RAM_BANK3  = 1'b1,
	parameter bit HAS_PERIPH_BANK8 = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	// Core data memory path
	input  wire logic        core_rd,
	input  wire logic        core_wr,
	input  wire logic [7:0]  core_addr,
	input  wire logic [7:0]  core_wdata,
	output logic      [7:0]  core_rdata,
	output logic             core_sfr_sel,
	output logic      [4:0]  core_sfr_index,
	input  wire logic [7:0]  core_sfr_rdata,
	// Literal bank loads from the instruction decoder
	input  wire logic        load_peripheral_bank_insn,
	input  wire logic        load_ram_bank_insn,
	input  wire logic [3:0]  bank_literal,
	// Bank select value seen by the rest of the core
	output logic      [7:0]  bank_select_reg,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [7:0]           bank_select;
		logic [1:0]           variant;
		logic [31:0]          prdata;
		dmb_pkg::dmb_region_e stat_region;
		logic                 stat_impl;
		logic [9:0]           stat_idx;
		logic [7:0]           core_rdata;
	} dmb_top_s;

	dmb_top_s st_q;
	dmb_top_s st_d;

	dmb_pkg::dmb_region_e region;
	logic                 impl;
	logic [6:0]           pidx;
	logic [2:0]           cidx;
	logic [9:0]           gidx;
	logic                 ram3_en;
	logic                 per8_en;
	logic [7:0]           per_rdata;
	logic [7:0]           cgpr_rdata;
	logic [7:0]           bgpr_rdata;
	logic                 per_we;
	logic                 cgpr_we;
	logic                 bgpr_we;
	logic                 core_we_ok;

	logic                 apb_setup;
	logic                 apb_access;
	logic                 apb_hit_bsel;
	logic                 apb_hit_var;
	logic                 apb_hit_stat;
	logic                 apb_mapped;
	logic [31:0]          apb_rword;

	////////////////////////////////////////////////////////////////////////////
	// Variant enables: software may only switch a present bank off

	assign ram3_en = HAS_RAM_BANK3 && st_q.variant[`DMB_VAR_RAM3_BIT]; // R8
	assign per8_en = HAS_PERIPH_BANK8 && st_q.variant[`DMB_VAR_PER8_BIT]; // R9

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	dmb_decode u_decode (
		.addr        (core_addr),
		.bank_select (st_q.bank_select),
		.ram3_en     (ram3_en),
		.per8_en     (per8_en),
		.region      (region),
		.impl        (impl),
		.pidx        (pidx),
		.cidx        (cidx),
		.gidx        (gidx)
	);

	// Writes to missing locations are dropped
	assign core_we_ok = core_wr && impl; // R7
	assign per_we     = core_we_ok && (region == dmb_pkg::DMB_REG_PERIPH); // R1
	assign cgpr_we    = core_we_ok && (region == dmb_pkg::DMB_REG_COMMON_GPR); // R4
	assign bgpr_we    = core_we_ok && (region == dmb_pkg::DMB_REG_BANKED_GPR); // R3

	////////////////////////////////////////////////////////////////////////////
	// Storage

	dmb_store #(
		.W     (8),
		.DEPTH (`DMB_PBANKS * 8),
		.AW    (7)
	) u_periph (
		.clock  (clock),
		.resetn (resetn),
		.we     (per_we),
		.widx   (pidx),
		.wdata  (core_wdata),
		.ridx   (pidx),
		.rdata  (per_rdata)
	);

	dmb_store #(
		.W     (8),
		.DEPTH (`DMB_CGPR_DEPTH),
		.AW    (3)
	) u_common_gpr (
		.clock  (clock),
		.resetn (resetn),
		.we     (cgpr_we),
		.widx   (cidx),
		.wdata  (core_wdata),
		.ridx   (cidx),
		.rdata  (cgpr_rdata)
	);

	// Trade-off: the small variant still builds bank 3 cells, just unreachable
	dmb_store #(
		.W     (8),
		.DEPTH (`DMB_RBANKS * `DMB_BGPR_SPAN),
		.AW    (10)
	) u_banked_gpr (
		.clock  (clock),
		.resetn (resetn),
		.we     (bgpr_we),
		.widx   (gidx),
		.wdata  (core_wdata),
		.ridx   (gidx),
		.rdata  (bgpr_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// Core register strobe out to the core, combinational

	always_comb begin
		core_sfr_sel   = (core_rd || core_wr) && (region == dmb_pkg::DMB_REG_CORE_SFR); // R2
		core_sfr_index = core_addr[4:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// APB decode, zero wait states

	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;
	assign apb_mapped = apb_hit_bsel || apb_hit_var || apb_hit_stat;

	// Full compare: upper address bits must be zero, so no aliases
	always_comb begin
		apb_hit_bsel = 1'b0;
		apb_hit_var  = 1'b0;
		apb_hit_stat = 1'b0;
		if (paddr == {22'h000000, `DMB_IDX_BANK_SELECT, 2'b00}) begin
			apb_hit_bsel = 1'b1;
		end else if (paddr == {22'h000000, `DMB_IDX_VARIANT, 2'b00}) begin
			apb_hit_var = 1'b1;
		end else if (paddr == {22'h000000, `DMB_IDX_STATUS, 2'b00}) begin
			apb_hit_stat = 1'b1;
		end
	end

	always_comb begin
		apb_rword = 32'h00000000;
		if (apb_hit_bsel) begin
			apb_rword = {24'h000000, st_q.bank_select};
		end else if (apb_hit_var) begin
			apb_rword = {30'h00000000, per8_en, ram3_en};
		end else if (apb_hit_stat) begin
			apb_rword = {16'h0000, 1'b0, st_q.stat_region, 1'b0, st_q.stat_impl, st_q.stat_idx};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d = st_q;

		// Read data captured in setup so it stands through the access phase
		if (apb_setup) begin
			st_d.prdata = apb_rword;
		end

		// Lowest priority: APB writes
		if (apb_access && pwrite) begin
			if (apb_hit_bsel) begin
				st_d.bank_select = pwdata[7:0];
			end else if (apb_hit_var) begin
				st_d.variant = pwdata[1:0];
			end
		end

		// Core store to the bank select location
		if (core_wr && (region == dmb_pkg::DMB_REG_BANK_SEL)) begin
			st_d.bank_select = core_wdata; // R2
		end

		// Literal loads touch only their own nibble
		if (load_peripheral_bank_insn) begin
			st_d.bank_select[3:0] = bank_literal; // R10
		end
		if (load_ram_bank_insn) begin
			st_d.bank_select[7:4] = bank_literal; // R11
		end

		// Core reads land one cycle later
		if (core_rd) begin
			st_d.core_rdata = 8'h00; // R7
			if (impl) begin
				case (region)
					dmb_pkg::DMB_REG_BANK_SEL: begin
						st_d.core_rdata = st_q.bank_select;
					end
					dmb_pkg::DMB_REG_CORE_SFR: begin
						st_d.core_rdata = core_sfr_rdata; // R5
					end
					dmb_pkg::DMB_REG_PERIPH: begin
						st_d.core_rdata = per_rdata; // R1
					end
					dmb_pkg::DMB_REG_COMMON_GPR: begin
						st_d.core_rdata = cgpr_rdata; // R4
					end
					dmb_pkg::DMB_REG_BANKED_GPR: begin
						st_d.core_rdata = bgpr_rdata; // R3
					end
					default: begin
						st_d.core_rdata = 8'h00;
					end
				endcase
			end
		end

		// Status keeps the decode of the last core access
		if (core_rd || core_wr) begin
			st_d.stat_region = region;
			st_d.stat_impl   = impl;
			if (region == dmb_pkg::DMB_REG_PERIPH) begin
				st_d.stat_idx = {3'b000, pidx};
			end else if (region == dmb_pkg::DMB_REG_COMMON_GPR) begin
				st_d.stat_idx = {7'h00, cidx};
			end else if (region == dmb_pkg::DMB_REG_BANKED_GPR) begin
				st_d.stat_idx = gidx;
			end else begin
				st_d.stat_idx = {2'b00, core_addr};
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q.bank_select <= `DMB_BANK_SELECT_RST;
			st_q.variant     <= `DMB_VARIANT_RST;
			st_q.prdata      <= 32'h00000000;
			st_q.stat_region <= dmb_pkg::DMB_REG_NONE;
			st_q.stat_impl   <= 1'b0;
			st_q.stat_idx    <= 10'h000;
			st_q.core_rdata  <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign core_rdata      = st_q.core_rdata;
	assign bank_select_reg = st_q.bank_select;
	assign prdata          = st_q.prdata;
	assign pready          = 1'b1;
	// Unmapped addresses answer with an error and read as zero
	assign pslverr         = apb_access && !apb_mapped;

endmodule

// file: verification/dmb_core_model.sv
/*
 Model of the core side: supplies values of unbanked core registers.
 Assumes the decoder raises core_sfr_sel for core register locations.
*/
`timescale 1ns/100ps

module dmb_core_model (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       core_sfr_sel,
	input  wire logic [4:0] core_sfr_index,
	output logic      [7:0] core_sfr_rdata
);
	logic [7:0] junk_q;

	// Changing filler when not selected, so stale data never matches
	// One process owns the filler register, reset seeds it
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			junk_q <= 8'hA5;
		end else begin
			junk_q <= junk_q + 8'h3B;
		end
	end
	assign core_sfr_rdata = core_sfr_sel ? {3'h6, core_sfr_index} : junk_q;
endmodule

// file: verification/dmb_top_asserts.sv
/*
 Port checker for dmb_top.
 Assumes it is bound to the top module by the bench.
*/
`timescale 1ns/100ps

module dmb_checker (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        core_rd,
	input wire logic        core_wr,
	input wire logic [7:0]  core_addr,
	input wire logic [7:0]  core_wdata,
	input wire logic [7:0]  core_rdata,
	input wire logic        core_sfr_sel,
	input wire logic [4:0]  core_sfr_index,
	input wire logic [7:0]  core_sfr_rdata,
	input wire logic        load_peripheral_bank_insn,
	input wire logic        load_ram_bank_insn,
	input wire logic [3:0]  bank_literal,
	input wire logic [7:0]  bank_select_reg,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_rd_sfr;
		core_rd && core_sfr_sel;
	endsequence
	sequence s_got_sfr;
		core_rdata == $past(core_sfr_rdata);
	endsequence
	property p_sfr_read;
		s_rd_sfr |=> s_got_sfr;
	endproperty
	property p_core_sel;
		(core_rd || core_wr) && core_addr <= 8'h0E |-> core_sfr_sel && core_sfr_index == core_addr[4:0];
	endproperty
	property p_lit_per;
		load_peripheral_bank_insn |=> bank_select_reg[3:0] == $past(bank_literal);
	endproperty
	property p_lit_ram;
		load_ram_bank_insn |=> bank_select_reg[7:4] == $past(bank_literal);
	endproperty
	property p_no_pbank;
		core_rd && bank_select_reg[3:0] > 4'h8 && core_addr[7:3] == 5'h02 |=> core_rdata == 8'h00;
	endproperty
	property p_no_rbank;
		core_rd && bank_select_reg[7:4] > 4'h3 && core_addr >= 8'h20 |=> core_rdata == 8'h00;
	endproperty
	property p_bsr_static;
		!load_peripheral_bank_insn && !load_ram_bank_insn && !(core_wr && core_addr == 8'h0F)
			&& !(psel && penable && pwrite) |=> $stable(bank_select_reg);
	endproperty
	property p_rdata_hold;
		!core_rd |=> $stable(core_rdata);
	endproperty
	property p_bsr_core_wr;
		core_wr && core_addr == 8'h0F && !load_peripheral_bank_insn && !load_ram_bank_insn
			|=> bank_select_reg == $past(core_wdata);
	endproperty

	a_sfr_read: assert property (p_sfr_read) else $error("core register read wrong");
	a_core_sel: assert property (p_core_sel) else $error("core register select wrong");
	a_lit_per: assert property (p_lit_per) else $error("peripheral bank load wrong");
	a_lit_ram: assert property (p_lit_ram) else $error("ram bank load wrong");
	a_no_pbank: assert property (p_no_pbank) else $error("absent peripheral bank not zero");
	a_no_rbank: assert property (p_no_rbank) else $error("absent ram bank not zero");
	a_bsr_static: assert property (p_bsr_static) else $error("bank select changed alone");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed alone");
	a_bsr_core_wr: assert property (p_bsr_core_wr) else $error("bank select write lost");
endmodule

// file: verification/dmb_top_tb.sv
/*
 Self-checking bench for dmb_top with the core model beside it.
 Assumes the zero-wait APB slave and one-cycle core read latency.
*/
`timescale 1ns/100ps
`include "dmb_regs.svh"

module dmb_top_tb;
	localparam logic [71:0] PM = `DMB_PMASK;
	logic        clock, resetn, core_rd, core_wr, core_sfr_sel;
	logic        load_peripheral_bank_insn, load_ram_bank_insn;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic [3:0]  bank_literal;
	logic [4:0]  core_sfr_index;
	logic [7:0]  core_addr, core_wdata, core_rdata, core_sfr_rdata, bank_select_reg, d;
	logic [31:0] paddr, pwdata, prdata, rv;
	int          fails, checks_done;

	dmb_top DUT (.clock, .resetn, .core_rd, .core_wr, .core_addr, .core_wdata, .core_rdata,
		.core_sfr_sel, .core_sfr_index, .core_sfr_rdata, .load_peripheral_bank_insn,
		.load_ram_bank_insn, .bank_literal, .bank_select_reg, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	dmb_core_model MDL (.clock, .resetn, .core_sfr_sel, .core_sfr_index, .core_sfr_rdata);

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		rv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(negedge clock);
	endtask

	task cwr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		core_wr <= 1'h1;
		core_addr <= a;
		core_wdata <= v;
		@(posedge clock);
		core_wr <= 1'h0;
		@(negedge clock);
	endtask

	task crd(input logic [7:0] a);
		@(posedge clock);
		core_rd <= 1'h1;
		core_addr <= a;
		@(posedge clock);
		core_rd <= 1'h0;
		@(negedge clock);
		d = core_rdata;
	endtask

	// Software switches banks through the literal loads; t_lit also switches them by core and APB writes
	task lit(input logic p, input logic r, input logic [3:0] v);
		@(posedge clock);
		load_peripheral_bank_insn <= p;
		load_ram_bank_insn <= r;
		bank_literal <= v;
		@(posedge clock);
		load_peripheral_bank_insn <= 1'h0;
		load_ram_bank_insn <= 1'h0;
		@(negedge clock);
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		chk("bsr", 8'h00, bank_select_reg);
		apb(1'h0, 32'h3C, 32'h0);
		chk("apb bsr", 32'h0, rv);
		chk("apb err", 1'h0, err);
		apb(1'h0, 32'h40, 32'h0);
		chk("variant", 32'h3, rv);
	endtask

	task t_lit;
		lit(1'h1, 1'h0, 4'h5);
		chk("pbank", 8'h05, bank_select_reg);
		lit(1'h0, 1'h1, 4'h2);
		chk("rbank", 8'h25, bank_select_reg);
		lit(1'h1, 1'h1, 4'hA);
		chk("both", 8'hAA, bank_select_reg);
		cwr(8'h0F, 8'h31);
		crd(8'h0F);
		chk("core bsr", 8'h31, d);
		apb(1'h1, 32'h3C, 32'h12);
		chk("apb bsr", 8'h12, bank_select_reg);
	endtask

	// Bank 9 has no storage at all, gaps come from the mask
	task t_periph;
		for (int b = 0; b < 10; b++) begin
			lit(1'h1, 1'h0, b[3:0]);
			for (int a = 0; a < 8; a++) cwr(8'h10 + a[7:0], {b[3:0], a[3:0]});
		end
		for (int b = 0; b < 10; b++) begin
			lit(1'h1, 1'h0, b[3:0]);
			for (int a = 0; a < 8; a++) begin
				crd(8'h10 + a[7:0]);
				chk("periph", (b < 9 && PM[b*8+a]) ? {b[3:0], a[3:0]} : 8'h00, d);
			end
		end
	endtask

	task t_ram;
		for (int b = 0; b < 5; b++) begin
			lit(1'h0, 1'h1, b[3:0]);
			cwr(8'h20, 8'h40 + b[7:0]);
			cwr(8'hFF, 8'h80 + b[7:0]);
		end
		for (int b = 0; b < 5; b++) begin
			lit(1'h0, 1'h1, b[3:0]);
			crd(8'h20);
			chk("ram lo", b < 4 ? 8'h40 + b[7:0] : 8'h00, d);
			crd(8'hFF);
			chk("ram hi", b < 4 ? 8'h80 + b[7:0] : 8'h00, d);
		end
		lit(1'h0, 1'h1, 4'h0);
		cwr(8'h1A, 8'h5C);
		lit(1'h0, 1'h1, 4'h3);
		crd(8'h1A);
		chk("common", 8'h5C, d);
	endtask

	task t_unbanked;
		for (int b = 0; b < 16; b += 7) begin
			lit(1'h1, 1'h1, b[3:0]);
			crd(8'h0E);
			chk("core reg", 8'hCE, d);
			crd(8'h19);
			chk("prod reg", 8'hD9, d);
		end
	endtask

	task t_variant;
		apb(1'h1, 32'h40, 32'h0);
		lit(1'h1, 1'h0, 4'h8);
		lit(1'h0, 1'h1, 4'h3);
		crd(8'h10);
		chk("no pbank8", 8'h00, d);
		crd(8'h20);
		chk("no rbank3", 8'h00, d);
		apb(1'h1, 32'h40, 32'h3);
		crd(8'h20);
		chk("rbank3 kept", 8'h43, d);
		lit(1'h0, 1'h1, 4'h2);
		crd(8'h25);
		apb(1'h0, 32'h44, 32'h0);
		chk("status", 32'h55C5, rv);
		apb(1'h0, 32'h48, 32'h0);
		chk("unmapped err", 1'h1, err);
		chk("unmapped data", 32'h0, rv);
	endtask

	////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Whole run takes some 500 cycles; allow ample margin
	initial begin
		#200000;
		fails++;
		wrap_up;
	end

	initial begin
		{resetn, core_rd, core_wr, psel, penable, pwrite} = 6'h00;
		{load_peripheral_bank_insn, load_ram_bank_insn, bank_literal} = 6'h00;
		{core_addr, core_wdata, paddr, pwdata} = 80'h0;
		{fails, checks_done} = 64'h0;
		repeat (4) @(posedge clock);
		resetn <= 1'h1;
		t_reset;
		t_lit;
		t_periph;
		t_ram;
		t_unbanked;
		t_variant;
		wrap_up;
	end
endmodule

bind dmb_top dmb_checker CHK (.clock, .resetn, .core_rd, .core_wr, .core_addr, .core_wdata,
	.core_rdata, .core_sfr_sel, .core_sfr_index, .core_sfr_rdata, .load_peripheral_bank_insn,
	.load_ram_bank_insn, .bank_literal, .bank_select_reg, .psel, .penable, .pwrite);
